// File: jsr_jog_ramp.sv
// Jog and normal speed reference ramp with an AXI4-Lite register slave
// How it works
// - Commands are sampled and the ramp advances once per 2 ms tick.
// - Jog alone ramps the reference up to jog speed at jog acceleration.
// - Jog alone holds the reference at jog speed once reached.
// - Jog released without run ramps to zero at jog deceleration, then stops.
// - Run ignores jog and ramps to normal reference at normal rates.
// - Once at normal target, run tracks the normal reference directly.
// - Run released without jog ramps to zero at normal deceleration.
// - Run released with jog ramps down to jog speed at jog deceleration.
// - The selected constant speed under run takes priority over jog speed.
// - Ramp shaping time is forced to zero while jogging.
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
module jsr_jog_ramp
	import jsr_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF,
	parameter int SPEED_W     = SPEED_W_DEF
) (
	// Clock, reset and enable
	input  wire logic                clock,
	input  wire logic                srst,
	input  wire logic                ce,
	// Command pins
	input  wire logic                jogPin,
	input  wire logic                startPin,
	// AXI4-Lite write
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// Ramp outputs
	output logic [SPEED_W-1:0]       speedRef,
	output jsr_mode_t                rampMode,
	output logic [SHAPE_W-1:0]       shapeTime
);
	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam logic [TW-1:0] TICK_RELOAD = TW'(TICK_CYCLES - 1);

	if (TICK_CYCLES < 1) begin
		$error("TICK_CYCLES must be at least 1");
	end
	if (SPEED_W < 1 || SPEED_W > 31) begin
		$error("SPEED_W must lie in 1..31");
	end

	// Merge write data into a word by byte strobes
	function automatic logic [31:0] mergeStrb(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				res[i*8 +: 8] = data[i*8 +: 8];
		end
		return res;
	endfunction

	// Address hits a mapped, aligned register
	function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
		return (addr[1:0] == 2'h0) && (addr <= OFS_SPEED);
	endfunction

	// One ramp step toward the target; zero step jumps straight there
	function automatic logic [SPEED_W-1:0] rampStep(
		input logic [SPEED_W-1:0] cur, input logic [SPEED_W-1:0] tgt,
		input logic [SPEED_W-1:0] up, input logic [SPEED_W-1:0] dn);
		logic [SPEED_W:0]   sum;
		logic [SPEED_W-1:0] res;
		sum = {1'b0, cur} + {1'b0, up};
		res = cur;
		if (cur < tgt) begin
			if (up == '0 || sum >= {1'b0, tgt})
				res = tgt;
			else
				res = sum[SPEED_W-1:0];
		end else if (cur > tgt) begin
			if (dn == '0 || dn >= cur - tgt)
				res = tgt;
			else
				res = cur - dn;
		end
		return res;
	endfunction

	// Bus and register state
	logic                awreadyReg, awreadyNext;
	logic                wreadyReg, wreadyNext;
	logic                awHeldReg, awHeldNext;
	logic                wHeldReg, wHeldNext;
	logic [ADDR_W-1:0]   awaddrReg, awaddrNext;
	logic [31:0]         wdataReg, wdataNext;
	logic [3:0]          wstrbReg, wstrbNext;
	logic                bvalidReg, bvalidNext;
	logic [1:0]          brespReg, brespNext;
	logic                arreadyReg, arreadyNext;
	logic                rvalidReg, rvalidNext;
	logic [31:0]         rdataReg, rdataNext;
	logic [1:0]          rrespReg, rrespNext;
	logic                constSelReg, constSelNext;
	logic [SPEED_W-1:0]  jogSpeedReg, jogSpeedNext;
	logic [SPEED_W-1:0]  runRefReg, runRefNext;
	logic [SPEED_W-1:0]  constSpdReg, constSpdNext;
	logic [SPEED_W-1:0]  jogAccReg, jogAccNext;
	logic [SPEED_W-1:0]  jogDecReg, jogDecNext;
	logic [SPEED_W-1:0]  runAccReg, runAccNext;
	logic [SPEED_W-1:0]  runDecReg, runDecNext;
	logic [SHAPE_W-1:0]  shapeReg, shapeNext;
	// Ramp state
	logic                jogMetaReg, jogSyncReg;
	logic                startMetaReg, startSyncReg;
	logic [TW-1:0]       tickCntReg, tickCntNext;
	jsr_mode_t           modeReg, modeNext;
	logic [SPEED_W-1:0]  speedReg, speedNext;
	logic                trackReg, trackNext;
	logic [SHAPE_W-1:0]  shapeOutReg, shapeOutNext;

	// Register file and AXI4-Lite handshakes
	always_comb begin
		logic [31:0] merged;
		logic [31:0] rd;
		merged = mergeStrb(32'h0, wdataReg, wstrbReg);
		rd = 32'h0;
		awreadyNext = awreadyReg;
		wreadyNext = wreadyReg;
		awHeldNext = awHeldReg;
		wHeldNext = wHeldReg;
		awaddrNext = awaddrReg;
		wdataNext = wdataReg;
		wstrbNext = wstrbReg;
		bvalidNext = bvalidReg;
		brespNext = brespReg;
		arreadyNext = arreadyReg;
		rvalidNext = rvalidReg;
		rdataNext = rdataReg;
		rrespNext = rrespReg;
		constSelNext = constSelReg;
		jogSpeedNext = jogSpeedReg;
		runRefNext = runRefReg;
		constSpdNext = constSpdReg;
		jogAccNext = jogAccReg;
		jogDecNext = jogDecReg;
		runAccNext = runAccReg;
		runDecNext = runDecReg;
		shapeNext = shapeReg;
		if (s_axi_awvalid && awreadyReg) begin
			awaddrNext = s_axi_awaddr;
			awreadyNext = 1'b0;
			awHeldNext = 1'b1;
		end
		if (s_axi_wvalid && wreadyReg) begin
			wdataNext = s_axi_wdata;
			wstrbNext = s_axi_wstrb;
			wreadyNext = 1'b0;
			wHeldNext = 1'b1;
		end
		if (awHeldReg && wHeldReg && !bvalidReg) begin
			awHeldNext = 1'b0;
			wHeldNext = 1'b0;
			bvalidNext = 1'b1;
			brespNext = isMapped(awaddrReg) ? RESP_OKAY : RESP_SLVERR;
			case (awaddrReg)
				OFS_CTRL: begin
					merged = mergeStrb(32'(constSelReg), wdataReg, wstrbReg);
					constSelNext = merged[CTRL_CONST_BIT];
				end
				OFS_JOG_SPEED: begin
					merged = mergeStrb(32'(jogSpeedReg), wdataReg, wstrbReg);
					jogSpeedNext = merged[SPEED_W-1:0];
				end
				OFS_RUN_REF: begin
					merged = mergeStrb(32'(runRefReg), wdataReg, wstrbReg);
					runRefNext = merged[SPEED_W-1:0];
				end
				OFS_CONST_SPD: begin
					merged = mergeStrb(32'(constSpdReg), wdataReg, wstrbReg);
					constSpdNext = merged[SPEED_W-1:0];
				end
				OFS_JOG_ACC: begin
					merged = mergeStrb(32'(jogAccReg), wdataReg, wstrbReg);
					jogAccNext = merged[SPEED_W-1:0];
				end
				OFS_JOG_DEC: begin
					merged = mergeStrb(32'(jogDecReg), wdataReg, wstrbReg);
					jogDecNext = merged[SPEED_W-1:0];
				end
				OFS_RUN_ACC: begin
					merged = mergeStrb(32'(runAccReg), wdataReg, wstrbReg);
					runAccNext = merged[SPEED_W-1:0];
				end
				OFS_RUN_DEC: begin
					merged = mergeStrb(32'(runDecReg), wdataReg, wstrbReg);
					runDecNext = merged[SPEED_W-1:0];
				end
				OFS_SHAPE: begin
					merged = mergeStrb(32'(shapeReg), wdataReg, wstrbReg);
					shapeNext = merged[SHAPE_W-1:0];
				end
				default: begin
					merged = 32'h0;
				end
			endcase
		end
		if (bvalidReg && s_axi_bready) begin
			bvalidNext = 1'b0;
			awreadyNext = 1'b1;
			wreadyNext = 1'b1;
		end
		case (s_axi_araddr)
			OFS_CTRL:      rd = 32'(constSelReg);
			OFS_JOG_SPEED: rd = 32'(jogSpeedReg);
			OFS_RUN_REF:   rd = 32'(runRefReg);
			OFS_CONST_SPD: rd = 32'(constSpdReg);
			OFS_JOG_ACC:   rd = 32'(jogAccReg);
			OFS_JOG_DEC:   rd = 32'(jogDecReg);
			OFS_RUN_ACC:   rd = 32'(runAccReg);
			OFS_RUN_DEC:   rd = 32'(runDecReg);
			OFS_SHAPE:     rd = 32'(shapeReg);
			OFS_STATUS: begin
				rd[STAT_MODE_LSB +: 5] = modeReg;
				rd[STAT_TRACK_BIT] = trackReg;
				rd[STAT_SHAPE_LSB +: SHAPE_W] = shapeOutReg;
			end
			OFS_SPEED:     rd = 32'(speedReg);
			default:       rd = 32'h0;
		endcase
		if (s_axi_arvalid && arreadyReg) begin
			arreadyNext = 1'b0;
			rvalidNext = 1'b1;
			rdataNext = rd;
			rrespNext = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (rvalidReg && s_axi_rready) begin
			rvalidNext = 1'b0;
			arreadyNext = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			awreadyReg <= 1'b1;
			wreadyReg <= 1'b1;
			awHeldReg <= 1'b0;
			wHeldReg <= 1'b0;
			awaddrReg <= '0;
			wdataReg <= 32'h0;
			wstrbReg <= 4'h0;
			bvalidReg <= 1'b0;
			brespReg <= RESP_OKAY;
			arreadyReg <= 1'b1;
			rvalidReg <= 1'b0;
			rdataReg <= 32'h0;
			rrespReg <= RESP_OKAY;
			constSelReg <= RST_CTRL[CTRL_CONST_BIT];
			jogSpeedReg <= RST_SPEED[SPEED_W-1:0];
			runRefReg <= RST_SPEED[SPEED_W-1:0];
			constSpdReg <= RST_SPEED[SPEED_W-1:0];
			jogAccReg <= RST_STEP[SPEED_W-1:0];
			jogDecReg <= RST_STEP[SPEED_W-1:0];
			runAccReg <= RST_STEP[SPEED_W-1:0];
			runDecReg <= RST_STEP[SPEED_W-1:0];
			shapeReg <= RST_SHAPE[SHAPE_W-1:0];
		end else if (ce) begin
			awreadyReg <= awreadyNext;
			wreadyReg <= wreadyNext;
			awHeldReg <= awHeldNext;
			wHeldReg <= wHeldNext;
			awaddrReg <= awaddrNext;
			wdataReg <= wdataNext;
			wstrbReg <= wstrbNext;
			bvalidReg <= bvalidNext;
			brespReg <= brespNext;
			arreadyReg <= arreadyNext;
			rvalidReg <= rvalidNext;
			rdataReg <= rdataNext;
			rrespReg <= rrespNext;
			constSelReg <= constSelNext;
			jogSpeedReg <= jogSpeedNext;
			runRefReg <= runRefNext;
			constSpdReg <= constSpdNext;
			jogAccReg <= jogAccNext;
			jogDecReg <= jogDecNext;
			runAccReg <= runAccNext;
			runDecReg <= runDecNext;
			shapeReg <= shapeNext;
		end
	end

	// Tick, mode and ramp
	always_comb begin
		logic [SPEED_W-1:0] runTarget;
		runTarget = constSelReg ? constSpdReg : runRefReg;
		tickCntNext = tickCntReg - 1'b1;
		modeNext = modeReg;
		speedNext = speedReg;
		trackNext = trackReg;
		if (tickCntReg == '0) begin
			tickCntNext = TICK_RELOAD;
			if (startSyncReg) begin
				modeNext = MODE_RUN;
				if (trackReg) begin
					speedNext = runTarget;
				end else begin
					speedNext = rampStep(speedReg, runTarget, runAccReg,
						runDecReg);
					trackNext = (speedNext == runTarget);
				end
			end else if (jogSyncReg) begin
				modeNext = MODE_JOG;
				trackNext = 1'b0;
				speedNext = rampStep(speedReg, jogSpeedReg, jogAccReg,
					jogDecReg);
			end else begin
				trackNext = 1'b0;
				case (modeReg)
					MODE_RUN, MODE_RUNSTOP: begin
						modeNext = MODE_RUNSTOP;
						speedNext = rampStep(speedReg, '0, runAccReg,
							runDecReg);
					end
					MODE_JOG, MODE_JOGSTOP: begin
						modeNext = MODE_JOGSTOP;
						speedNext = rampStep(speedReg, '0, jogAccReg,
							jogDecReg);
					end
					default: begin
						speedNext = '0;
					end
				endcase
				if (speedNext == '0)
					modeNext = MODE_IDLE;
			end
		end
		if (modeNext == MODE_JOG || modeNext == MODE_JOGSTOP)
			shapeOutNext = '0;
		else
			shapeOutNext = shapeReg;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			jogMetaReg <= 1'b0;
			jogSyncReg <= 1'b0;
			startMetaReg <= 1'b0;
			startSyncReg <= 1'b0;
			tickCntReg <= TICK_RELOAD;
			modeReg <= MODE_IDLE;
			speedReg <= '0;
			trackReg <= 1'b0;
			shapeOutReg <= RST_SHAPE[SHAPE_W-1:0];
		end else if (ce) begin
			jogMetaReg <= jogPin;
			jogSyncReg <= jogMetaReg;
			startMetaReg <= startPin;
			startSyncReg <= startMetaReg;
			tickCntReg <= tickCntNext;
			modeReg <= modeNext;
			speedReg <= speedNext;
			trackReg <= trackNext;
			shapeOutReg <= shapeOutNext;
		end
	end

	assign s_axi_awready = awreadyReg;
	assign s_axi_wready = wreadyReg;
	assign s_axi_bresp = brespReg;
	assign s_axi_bvalid = bvalidReg;
	assign s_axi_arready = arreadyReg;
	assign s_axi_rdata = rdataReg;
	assign s_axi_rresp = rrespReg;
	assign s_axi_rvalid = rvalidReg;
	assign speedRef = speedReg;
	assign rampMode = modeReg;
	assign shapeTime = shapeOutReg;
endmodule

// File: jsr_pkg.sv
// Constants, register map and types for the jog speed reference ramp
package jsr_pkg;
	// Tick timing
	localparam int TICK_TIME_MS    = 2;
	localparam int CLK_FREQ_KHZ    = 125000;
	localparam int TICK_CYCLES_DEF = TICK_TIME_MS * CLK_FREQ_KHZ;
	// Widths
	localparam int SPEED_W_DEF = 16;
	localparam int SHAPE_W     = 16;
	localparam int ADDR_W      = 8;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_JOG_SPEED = 8'h04;
	localparam logic [7:0] OFS_RUN_REF   = 8'h08;
	localparam logic [7:0] OFS_CONST_SPD = 8'h0C;
	localparam logic [7:0] OFS_JOG_ACC   = 8'h10;
	localparam logic [7:0] OFS_JOG_DEC   = 8'h14;
	localparam logic [7:0] OFS_RUN_ACC   = 8'h18;
	localparam logic [7:0] OFS_RUN_DEC   = 8'h1C;
	localparam logic [7:0] OFS_SHAPE     = 8'h20;
	localparam logic [7:0] OFS_STATUS    = 8'h24;
	localparam logic [7:0] OFS_SPEED     = 8'h28;
	// Field positions
	localparam int CTRL_CONST_BIT  = 0;
	localparam int STAT_MODE_LSB   = 0;
	localparam int STAT_TRACK_BIT  = 8;
	localparam int STAT_SHAPE_LSB  = 16;
	// Values after reset
	localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
	localparam logic [31:0] RST_SPEED = 32'h0000_0000;
	localparam logic [31:0] RST_STEP  = 32'h0000_0001;
	localparam logic [31:0] RST_SHAPE = 32'h0000_0000;
	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Ramp modes
	typedef enum logic [4:0] {
		MODE_IDLE    = 5'h01,
		MODE_JOG     = 5'h02,
		MODE_JOGSTOP = 5'h04,
		MODE_RUN     = 5'h08,
		MODE_RUNSTOP = 5'h10
	} jsr_mode_t;
endpackage

// File: jsr_jog_ramp_sva.sv
// Assertion checker for the jog speed reference ramp
module jsr_jog_ramp_sva
	import jsr_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF,
	parameter int SPEED_W     = SPEED_W_DEF
) (
	// Clock and commands
	input wire logic               clock,
	input wire logic               srst,
	input wire logic               ce,
	input wire logic               jogPin,
	input wire logic               startPin,
	// Write handshakes
	input wire logic               s_axi_awvalid,
	input wire logic               s_axi_awready,
	input wire logic               s_axi_wvalid,
	input wire logic               s_axi_wready,
	input wire logic               s_axi_bvalid,
	// Ramp outputs
	input wire logic [SPEED_W-1:0] speedRef,
	input wire jsr_mode_t          rampMode,
	input wire logic [SHAPE_W-1:0] shapeTime
);
	timeunit 1ns;
	timeprecision 1ns;
	int   tickCnt_reg;
	int   tickCnt_next;
	logic tickNow;
	// Mirror of the tick counter
	always_comb begin
		tickCnt_next = tickCnt_reg;
		if (ce)
			tickCnt_next = (tickCnt_reg == 0) ? TICK_CYCLES - 1 : tickCnt_reg - 1;
		if (srst)
			tickCnt_next = TICK_CYCLES - 1;
	end
	always_ff @(posedge clock) begin
		tickCnt_reg <= tickCnt_next;
	end
	assign tickNow = ce && !srst && tickCnt_reg == 0;
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	rst_clear_a: assert property (disable iff (1'b0) srst |=>
		speedRef == '0 && rampMode == MODE_IDLE && shapeTime == '0)
		else $error("reset did not clear the ramp");
	tick_only_a: assert property (!tickNow |=>
		$stable(speedRef) && $stable(rampMode))
		else $error("ramp moved between ticks");
	jog_shape_a: assert property (
		rampMode inside {MODE_JOG, MODE_JOGSTOP} |-> shapeTime == '0)
		else $error("shape time not zero in jog");
	idle_zero_a: assert property (rampMode == MODE_IDLE
		|-> speedRef == '0) else $error("idle with nonzero speed");
	run_prio_a: assert property (tickNow && $past(startPin, 2)
		|=> rampMode == MODE_RUN) else $error("run did not override jog");
	jog_mode_a: assert property (tickNow && $past(jogPin, 2)
		&& !$past(startPin, 2) |=> rampMode == MODE_JOG)
		else $error("jog request not followed");
	jog_stop_a: assert property (tickNow && !$past(jogPin, 2)
		&& !$past(startPin, 2) && speedRef != '0
		&& rampMode inside {MODE_JOG, MODE_JOGSTOP}
		|=> rampMode inside {MODE_JOGSTOP, MODE_IDLE}
		&& speedRef < $past(speedRef)) else $error("jog stop wrong");
	run_stop_a: assert property (tickNow && !$past(jogPin, 2)
		&& !$past(startPin, 2) && speedRef != '0
		&& rampMode inside {MODE_RUN, MODE_RUNSTOP}
		|=> rampMode inside {MODE_RUNSTOP, MODE_IDLE}
		&& speedRef < $past(speedRef)) else $error("run stop wrong");
	write_resp_a: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response late");
	cover property (tickNow && rampMode == MODE_RUN);
	cover property ($rose(rampMode == MODE_JOGSTOP));
	cover property ($rose(rampMode == MODE_RUNSTOP));
endmodule

bind jsr_jog_ramp jsr_jog_ramp_sva #(
	.TICK_CYCLES(TICK_CYCLES),
	.SPEED_W(SPEED_W)
) i_sva (
	.clock, .srst, .ce, .jogPin, .startPin, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.speedRef, .rampMode, .shapeTime
);

// File: jsr_motor_model.sv
// Motor speed loop model fed by the ramped reference
module jsr_motor_model #(
	parameter int SPEED_W = 16
) (
	// Clock and reset
	input wire logic               clock,
	input wire logic               srst,
	// Reference in, shaft speed out
	input wire logic [SPEED_W-1:0] speedRef,
	output logic     [SPEED_W-1:0] motorSpeed
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [SPEED_W-1:0] speed_reg;
	logic [SPEED_W-1:0] speed_next;
	// Shaft settles on the reference one cycle later
	always_comb begin
		speed_next = srst ? '0 : speedRef;
	end
	always_ff @(posedge clock) begin
		speed_reg <= speed_next;
	end
	assign motorSpeed = speed_reg;
endmodule

// File: jog_speed_reference_control_bench.sv
// Self-checking bench for the jog speed reference ramp
module jog_speed_reference_control_bench
	import jsr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TCY   = 8;
	localparam int LIMIT = 3000;
	logic        clock;
	logic        srst = 1'b1, ce = 1'b1, jogPin = 1'b0, startPin = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [15:0] speedRef, shapeTime, motorSpeed;
	jsr_mode_t   rampMode;
	int          cyc = 0, runCycles = 0, errTotal = 0, numChecks = 0;
	jsr_jog_ramp #(.TICK_CYCLES(TCY), .SPEED_W(16)) i_dut (
		.clock, .srst, .ce, .jogPin, .startPin,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .speedRef, .rampMode, .shapeTime
	);
	jsr_motor_model #(.SPEED_W(16)) i_motor (
		.clock, .srst, .speedRef, .motorSpeed
	);
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc <= srst ? 0 : cyc + 1;
		runCycles++;
		if (runCycles == LIMIT) begin
			errTotal++;
			conclude();
		end
	end
	task chk(input string what, input logic [31:0] seen, exp);
		numChecks++;
		if (seen !== exp) begin
			errTotal++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hF, input logic [1:0] r = RESP_OKAY);
		@(posedge clock);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", 32'(s_axi_bresp), 32'(r));
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge clock);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk("rdata", s_axi_rdata, e);
		chk("rresp", 32'(s_axi_rresp), 32'(r));
	endtask
	task tickw();
		do begin
			@(posedge clock);
			#1;
		end while (cyc % TCY != 0);
	endtask
	task pins(input logic j, input logic s);
		@(posedge clock);
		jogPin   <= j;
		startPin <= s;
	endtask
	task tk(input logic [15:0] sp, input jsr_mode_t m);
		logic [31:0] shp;
		shp = (m == MODE_JOG || m == MODE_JOGSTOP) ? 32'h0 : 32'h5;
		tickw();
		chk("speedRef", 32'(speedRef), 32'(sp));
		chk("rampMode", 32'(rampMode), 32'(m));
		chk("shapeTime", 32'(shapeTime), shp);
	endtask
	task conclude();
		$display("checks %0d mismatches %0d", numChecks, errTotal);
		if (errTotal == 0 && numChecks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clock);
		srst <= 1'b0;
		rd(OFS_JOG_ACC, RST_STEP, RESP_OKAY);
		rd(OFS_STATUS, 32'h1, RESP_OKAY);
		rd(8'h2C, 32'h0, RESP_SLVERR);
		wr(OFS_RUN_REF, 32'h1234_5678, 4'h2);
		rd(OFS_RUN_REF, 32'h0000_5600, RESP_OKAY);
		wr(8'h2D, 32'h1, 4'hF, RESP_SLVERR);
		wr(OFS_SPEED, 32'hFF);
		rd(OFS_SPEED, 32'h0, RESP_OKAY);
		wr(OFS_JOG_SPEED, 32'hA);
		wr(OFS_JOG_ACC, 32'h4);
		wr(OFS_JOG_DEC, 32'h3);
		wr(OFS_SHAPE, 32'h5);
		tickw();
		pins(1'b1, 1'b0);
		tk(16'h4, MODE_JOG);
		@(posedge clock);
		ce <= 1'b0;
		repeat (16) @(posedge clock);
		ce <= 1'b1;
		chk("speedRef", 32'(speedRef), 32'h4);
		tk(16'h8, MODE_JOG);
		tk(16'hA, MODE_JOG);
		tk(16'hA, MODE_JOG);
		pins(1'b0, 1'b0);
		tk(16'h7, MODE_JOGSTOP);
		tk(16'h4, MODE_JOGSTOP);
		tk(16'h1, MODE_JOGSTOP);
		tk(16'h0, MODE_IDLE);
		tk(16'h0, MODE_IDLE);
		wr(OFS_CONST_SPD, 32'h32);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_RUN_REF, 32'h28);
		wr(OFS_RUN_ACC, 32'h14);
		wr(OFS_RUN_DEC, 32'hF);
		wr(OFS_JOG_DEC, 32'hF);
		tickw();
		pins(1'b1, 1'b1);
		tk(16'h14, MODE_RUN);
		tk(16'h28, MODE_RUN);
		tk(16'h32, MODE_RUN);
		tk(16'h32, MODE_RUN);
		wr(OFS_CTRL, 32'h0);
		tk(16'h28, MODE_RUN);
		wr(OFS_CTRL, 32'h1);
		tk(16'h32, MODE_RUN);
		pins(1'b1, 1'b0);
		tk(16'h23, MODE_JOG);
		tk(16'h14, MODE_JOG);
		tk(16'hA, MODE_JOG);
		tk(16'hA, MODE_JOG);
		pins(1'b0, 1'b1);
		tk(16'h1E, MODE_RUN);
		tk(16'h32, MODE_RUN);
		pins(1'b0, 1'b0);
		tk(16'h23, MODE_RUNSTOP);
		tk(16'h14, MODE_RUNSTOP);
		tk(16'h5, MODE_RUNSTOP);
		tk(16'h0, MODE_IDLE);
		pins(1'b1, 1'b0);
		tk(16'h4, MODE_JOG);
		@(posedge clock);
		srst <= 1'b1;
		repeat (4) @(posedge clock);
		#1;
		chk("speedRef", 32'(speedRef), 32'h0);
		chk("rampMode", 32'(rampMode), 32'(MODE_IDLE));
		chk("motorSpeed", 32'(motorSpeed), 32'h0);
		@(posedge clock);
		srst <= 1'b0;
		rd(OFS_SPEED, 32'h0, RESP_OKAY);
		conclude();
	end
endmodule
